// >>> pkg/hsro_pkg.sv
// Package with register map, field layout, reset values and states of the handler sort block
// Function
// - End-of-test strobe rises once the bin assignment is valid for sorting.
// - Acquisition-done strobe rises when acquisition ends, before calculation finishes.
// - Measure function with triggered mode starts on handler start or button.
// - End-of-test and pass/fail only when a non-zero nominal is held.
// - Basic variant merges bins 9 to 13 into bin 14; high-speed drives 15.
// - Output codes 0 to 7: 1 bin, 2 secondary, 4 primary, sums combine.
// - Code 8 sends nothing on pass, code 9 bin on pass; failures send all.
// - With output enabled, selected strings go out after every measurement sequence.
// - Primary and secondary strings are 17 characters, bin strings 10.
// - Setting writes are accepted only while keypad entry function is selected.
// - Digit blanking holds separate primary and secondary digit counts.
// - Integration factor spans 0.25 to 6 in quarters, default 1.
// - Ratio code 0 normal, 1 nominal over measured, 2 measured over nominal.
// - Parameter code 0 manual, 1 automatic default; code 2 restores all defaults.
// - Median setting 1 reports median of 3 measurements, 0 a single one.
// - Listener address, firmware version and frequency correction are readable only.
// - Every transmitted string ends with carriage return then line feed.
package hsro_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SETUP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;
    localparam logic [7:0] OFS_INFO = 8'h10;
    localparam logic [7:0] OFS_STRBUF = 8'h40;
    localparam logic [7:0] STRBUF_MASK = 8'hc0;
    // Control register bits
    localparam int CTRL_ENTRY = 0;
    localparam int CTRL_MEASURE = 1;
    localparam int CTRL_TRIG = 2;
    localparam int CTRL_HISPEED = 3;
    localparam int CTRL_BUTTON = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;
    // Setup register fields
    localparam int SU_OUT_LO = 0;
    localparam int SU_BLKP_LO = 4;
    localparam int SU_BLKS_LO = 8;
    localparam int SU_INTEG_LO = 12;
    localparam int SU_RATIO_LO = 18;
    localparam int SU_PARAM_LO = 20;
    localparam int SU_MEDIAN = 24;
    localparam logic [24:0] SETUP_RST = 25'h0104000;
    localparam logic [24:0] SETUP_MASK = 25'h13df77f;
    // Legal codes
    localparam logic [3:0] OUT_MAX = 4'h9;
    localparam logic [3:0] OUT_PASS_NONE = 4'h8;
    localparam logic [3:0] OUT_PASS_BIN = 4'h9;
    localparam logic [4:0] INTEG_MIN = 5'h01;
    localparam logic [4:0] INTEG_MAX = 5'h18;
    localparam logic [1:0] RATIO_MAX = 2'h2;
    localparam logic [1:0] PARAM_RESTORE = 2'h2;
    localparam logic [1:0] MED_LAST = 2'h2;
    // Bins
    localparam int NBINS = 15;
    localparam logic [3:0] BIN_MERGE_LO = 4'h9;
    localparam logic [3:0] BIN_MERGE_HI = 4'hd;
    localparam logic [3:0] BIN_MERGE_TO = 4'he;
    // String segments and lengths
    localparam logic [1:0] SEG_PRI = 2'h0;
    localparam logic [1:0] SEG_SEC = 2'h1;
    localparam logic [1:0] SEG_BIN = 2'h2;
    localparam logic [4:0] PRI_LEN = 5'h11;
    localparam logic [4:0] SEC_LEN = 5'h11;
    localparam logic [4:0] BIN_LEN = 5'h0a;
    localparam logic [7:0] CHR_CR = 8'h0d;
    localparam logic [7:0] CHR_LF = 8'h0a;
    // Firmware version, arbitrary value
    localparam logic [7:0] FW_VERSION = 8'h01;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_MEAS = 7'b0000010,
        ST_CALC = 7'b0000100,
        ST_PICK = 7'b0001000,
        ST_FETCH = 7'b0010000,
        ST_LOAD = 7'b0100000,
        ST_TX = 7'b1000000
    } hsro_state_e;
endpackage

// >>> rtl/hsro_strbuf.sv
// Result string buffer: one write port, one registered read port
`timescale 1ns/100ps
module hsro_strbuf (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data_q
);
    logic [7:0] mem [0:63];

    // Write and registered read
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule // hsro_strbuf

// >>> rtl/hsro_top.sv
// Handler sequencing, bin outputs, settings registers and result string sender
`timescale 1ns/100ps
module hsro_top
    import hsro_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic handler_start,
    input wire logic eng_capt_done,
    input wire logic eng_calc_done,
    input wire logic [15:0] eng_value,
    input wire logic [3:0] eng_bin,
    input wire logic eng_pass,
    input wire logic nominal_nonzero,
    input wire logic [4:0] listen_addr,
    input wire logic [15:0] freq_corr,
    output logic meas_start,
    output logic end_of_test_strobe,
    output logic acquisition_done_strobe,
    output logic [NBINS-1:0] handler_bin,
    output logic pass_ind,
    output logic fail_ind,
    output logic [24:0] cfg_setup,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    hsro_state_e state_q, state_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic [24:0] setup_q, setup_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic start_prev_q, button_q, button_d;
    logic meas_start_q, meas_start_d, test_end_q, test_end_d, capt_q, capt_d, pass_q, pass_d, fail_q, fail_d;
    logic [NBINS-1:0] bins_q, bins_d, bin_hot;
    logic [1:0] med_cnt_q, med_cnt_d, seg_q, seg_d;
    logic [15:0] v0_q, v0_d, v1_q, v1_d, result_q, result_d, med_val;
    logic [3:0] bin_num_q, bin_num_d, bin_map;
    logic [2:0] mask_q, mask_d, sel_mask;
    logic [4:0] idx_q, idx_d, seg_len;
    logic tx_valid_q, tx_valid_d;
    logic [7:0] tx_data_q, tx_data_d, mem_rd;
    logic acc, wr_strobe, wr_setup, wr_buf, start_evt, setup_legal;
    logic [24:0] su_new;

    assign acc = psel & penable;
    assign wr_strobe = acc & pready_q & pwrite;
    assign wr_setup = wr_strobe & (paddr == OFS_SETUP) & ctrl_q[CTRL_ENTRY];
    assign wr_buf = wr_strobe & (paddr >= OFS_STRBUF);
    assign su_new = pwdata[24:0] & SETUP_MASK;

    // A setting write is taken whole only when the output, integration and ratio codes are legal; restore always wins
    assign setup_legal = (su_new[SU_OUT_LO +: 4] <= OUT_MAX)
                       && (su_new[SU_INTEG_LO +: 5] >= INTEG_MIN)
                       && (su_new[SU_INTEG_LO +: 5] <= INTEG_MAX)
                       && (su_new[SU_RATIO_LO +: 2] <= RATIO_MAX);

    // Start event: rising handler edge or button, only in triggered measure mode
    assign start_evt = ((handler_start & ~start_prev_q) | button_q)
                     & ctrl_q[CTRL_MEASURE] & ctrl_q[CTRL_TRIG];

    // Median of three and basic-variant bin merge
    assign med_val = (v0_q < v1_q) ? ((v1_q < eng_value) ? v1_q : ((v0_q < eng_value) ? eng_value : v0_q))
                                   : ((v0_q < eng_value) ? v0_q : ((v1_q < eng_value) ? eng_value : v1_q));
    assign bin_map = (!ctrl_q[CTRL_HISPEED] && eng_bin >= BIN_MERGE_LO && eng_bin <= BIN_MERGE_HI)
                   ? BIN_MERGE_TO : eng_bin;

    // One-hot handler bin decode
    genvar gi;
    generate
        for (gi = 0; gi < NBINS; gi++) begin : g_bin
            assign bin_hot[gi] = (bin_map == 4'(gi));
        end
    endgenerate

    // Output selection: bit 2 primary, bit 1 secondary, bit 0 bin; codes 8 and 9 depend on pass
    always_comb begin
        case (setup_q[SU_OUT_LO +: 4])
            OUT_PASS_NONE: sel_mask = eng_pass ? 3'h0 : 3'h7;
            OUT_PASS_BIN: sel_mask = eng_pass ? 3'h4 : 3'h7;
            default: sel_mask = {setup_q[SU_OUT_LO], setup_q[SU_OUT_LO + 1], setup_q[SU_OUT_LO + 2]};
        endcase
    end

    assign seg_len = (seg_q == SEG_BIN) ? BIN_LEN : ((seg_q == SEG_SEC) ? SEC_LEN : PRI_LEN);

    // APB register access and settings
    always_comb begin
        ctrl_d = ctrl_q;
        setup_d = setup_q;
        button_d = 1'b0;
        pready_d = acc & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h0;
        if (wr_strobe && paddr == OFS_CTRL) begin
            ctrl_d = pwdata[3:0];
            button_d = pwdata[CTRL_BUTTON];
        end
        if (wr_setup) begin
            if (su_new[SU_PARAM_LO +: 2] == PARAM_RESTORE) begin
                setup_d = SETUP_RST;
            end else if (setup_legal) begin
                setup_d = su_new;
            end
        end
        if (acc && !pready_q) begin
            case (paddr)
                OFS_CTRL: prdata_d = {28'h0, ctrl_q};
                OFS_SETUP: prdata_d = {7'h0, setup_q};
                OFS_STATUS: prdata_d = {22'h0, med_cnt_q, bin_num_q, pass_q, capt_q, test_end_q, ~state_q[0]};
                OFS_RESULT: prdata_d = {16'h0, result_q};
                OFS_INFO: prdata_d = {freq_corr, 3'h0, listen_addr, FW_VERSION};
                default: pslverr_d = (paddr < OFS_STRBUF);
            endcase
        end
    end

    // Sequencer: measurement, median collection, strobes, bins and string sending
    always_comb begin
        state_d = state_q;
        meas_start_d = 1'b0;
        test_end_d = test_end_q;
        capt_d = capt_q;
        pass_d = pass_q;
        fail_d = fail_q;
        bins_d = bins_q;
        med_cnt_d = med_cnt_q;
        v0_d = v0_q;
        v1_d = v1_q;
        result_d = result_q;
        bin_num_d = bin_num_q;
        mask_d = mask_q;
        seg_d = seg_q;
        idx_d = idx_q;
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        case (state_q)
            ST_IDLE: begin
                if (start_evt) begin
                    meas_start_d = 1'b1;
                    test_end_d = 1'b0;
                    capt_d = 1'b0;
                    pass_d = 1'b0;
                    fail_d = 1'b0;
                    bins_d = '0;
                    med_cnt_d = 2'h0;
                    state_d = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (eng_capt_done) begin
                    if (!setup_q[SU_MEDIAN] || med_cnt_q == MED_LAST) begin
                        capt_d = 1'b1;
                    end
                    state_d = ST_CALC;
                end
            end
            ST_CALC: begin
                if (eng_calc_done) begin
                    if (setup_q[SU_MEDIAN] && med_cnt_q != MED_LAST) begin
                        v0_d = v1_q;
                        v1_d = eng_value;
                        med_cnt_d = med_cnt_q + 2'h1;
                        meas_start_d = 1'b1;
                        state_d = ST_MEAS;
                    end else begin
                        result_d = setup_q[SU_MEDIAN] ? med_val : eng_value;
                        bin_num_d = eng_bin;
                        if (nominal_nonzero) begin
                            test_end_d = 1'b1;
                            bins_d = bin_hot;
                            pass_d = eng_pass;
                            fail_d = ~eng_pass;
                        end
                        mask_d = sel_mask;
                        seg_d = SEG_PRI;
                        idx_d = 5'h0;
                        state_d = (sel_mask != 3'h0) ? ST_PICK : ST_IDLE;
                    end
                end
            end
            ST_PICK: begin
                if (mask_q[0]) begin
                    state_d = ST_FETCH;
                end else if (mask_q == 3'h0) begin
                    state_d = ST_IDLE;
                end else begin
                    mask_d = {1'b0, mask_q[2:1]};
                    seg_d = seg_q + 2'h1;
                end
            end
            ST_FETCH: state_d = ST_LOAD;
            ST_LOAD: begin
                if (idx_q < seg_len - 5'h2) begin
                    tx_data_d = mem_rd;
                end else if (idx_q == seg_len - 5'h2) begin
                    tx_data_d = CHR_CR;
                end else begin
                    tx_data_d = CHR_LF;
                end
                tx_valid_d = 1'b1;
                state_d = ST_TX;
            end
            ST_TX: begin
                if (tx_ready) begin
                    tx_valid_d = 1'b0;
                    if (idx_q == seg_len - 5'h1) begin
                        idx_d = 5'h0;
                        mask_d = {1'b0, mask_q[2:1]};
                        seg_d = seg_q + 2'h1;
                        state_d = ST_PICK;
                    end else begin
                        idx_d = idx_q + 5'h1;
                        state_d = ST_FETCH;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ctrl_q <= CTRL_RST;
            setup_q <= SETUP_RST;
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            start_prev_q <= 1'b0;
            button_q <= 1'b0;
            meas_start_q <= 1'b0;
            test_end_q <= 1'b0;
            capt_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            bins_q <= '0;
            med_cnt_q <= 2'h0;
            v0_q <= 16'h0;
            v1_q <= 16'h0;
            result_q <= 16'h0;
            bin_num_q <= 4'h0;
            mask_q <= 3'h0;
            seg_q <= 2'h0;
            idx_q <= 5'h0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h0;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            setup_q <= setup_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            start_prev_q <= handler_start;
            button_q <= button_d;
            meas_start_q <= meas_start_d;
            test_end_q <= test_end_d;
            capt_q <= capt_d;
            pass_q <= pass_d;
            fail_q <= fail_d;
            bins_q <= bins_d;
            med_cnt_q <= med_cnt_d;
            v0_q <= v0_d;
            v1_q <= v1_d;
            result_q <= result_d;
            bin_num_q <= bin_num_d;
            mask_q <= mask_d;
            seg_q <= seg_d;
            idx_q <= idx_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
        end
    end

    // String buffer: software writes formatted characters, sender reads them
    hsro_strbuf u_strbuf (
        .clk(pclk),
        .wr_en(wr_buf),
        .wr_addr({2'(paddr[7:6] - 2'h1), paddr[5:2]}),
        .wr_data(pwdata[7:0]),
        .rd_addr({seg_q, idx_q[3:0]}),
        .rd_data_q(mem_rd)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign meas_start = meas_start_q;
    assign end_of_test_strobe = test_end_q;
    assign acquisition_done_strobe = capt_q;
    assign handler_bin = bins_q;
    assign pass_ind = pass_q;
    assign fail_ind = fail_q;
    assign cfg_setup = setup_q;
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_end_nominal;
        $rose(test_end_q) |-> $past(nominal_nonzero) && $past(state_q) == ST_CALC;
    endproperty
    a_end_nominal: assert property (p_end_nominal) else $error("end of test without nominal");

    property p_capt_first;
        $rose(test_end_q) |-> capt_q;
    endproperty
    a_capt_first: assert property (p_capt_first) else $error("end of test before acquisition");

    property p_start_clears;
        (state_q == ST_IDLE && start_evt) |=> meas_start_q && !test_end_q && !capt_q && state_q == ST_MEAS;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not begin cleanly");

    property p_no_restart;
        (state_q inside {ST_PICK, ST_FETCH, ST_LOAD, ST_TX}) |=> !meas_start_q;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("start taken while sending");

    property p_bin_merge;
        (state_q == ST_CALC && eng_calc_done && !ctrl_q[CTRL_HISPEED]) |=> bins_q[13:9] == 5'h0;
    endproperty
    a_bin_merge: assert property (p_bin_merge) else $error("merged bin driven");

    property p_crlf;
        (state_q == ST_LOAD && idx_q == seg_len - 5'h1) |=> tx_valid_q && tx_data_q == CHR_LF;
    endproperty
    a_crlf: assert property (p_crlf) else $error("string not ended by line feed");

    property p_gate;
        (wr_strobe && paddr == OFS_SETUP && !ctrl_q[CTRL_ENTRY]) |=> $stable(setup_q);
    endproperty
    a_gate: assert property (p_gate) else $error("setting changed outside entry");

    property p_restore;
        (wr_setup && su_new[SU_PARAM_LO +: 2] == PARAM_RESTORE) |=> setup_q == SETUP_RST;
    endproperty
    a_restore: assert property (p_restore) else $error("restore did not reset settings");

    property p_none;
        (state_q == ST_CALC && eng_calc_done && !setup_q[SU_MEDIAN] && setup_q[SU_OUT_LO +: 4] == 4'h0)
            |=> state_q == ST_IDLE ##1 !tx_valid_q;
    endproperty
    a_none: assert property (p_none) else $error("output sent with code zero");

    property p_integ;
        setup_q[SU_INTEG_LO +: 5] >= INTEG_MIN && setup_q[SU_INTEG_LO +: 5] <= INTEG_MAX;
    endproperty
    a_integ: assert property (p_integ) else $error("integration factor out of range");
endmodule // hsro_top

// >>> tb/hsro_partner.sv
// Handler and listener model: part connect delay, start level, byte sink with stalls
`timescale 1ns/100ps
module hsro_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic part_req,
    input wire logic stall,
    input wire logic glue_on,
    input wire logic test_end,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic handler_start,
    output logic tx_ready,
    output logic [15:0] rx_count,
    output logic [31:0] rx_tail
);
    logic [2:0] conn_q;
    // Start rises once the part has sat a few cycles, gated by end of test when glue is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conn_q <= 3'h0;
            handler_start <= 1'b0;
            tx_ready <= 1'b0;
            rx_count <= 16'h0000;
            rx_tail <= 32'h0;
        end else begin
            if (!part_req) begin
                conn_q <= 3'h0;
                handler_start <= 1'b0;
            end else if (conn_q != 3'h4) begin
                conn_q <= conn_q + 3'h1;
            end else begin
                handler_start <= !glue_on | test_end;
            end
            tx_ready <= !stall;
            if (tx_valid && tx_ready) begin
                rx_count <= rx_count + 16'h0001;
                rx_tail <= {rx_tail[23:0], tx_data};
            end
        end
    end
endmodule // hsro_partner

// >>> tb/test_hsro_top.sv
// Self-checking bench for handler sequencing, settings and result output
`timescale 1ns/100ps
module test_hsro_top;
    import hsro_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, stall, part_req, glue_on;
    logic handler_start, eng_capt_done, eng_calc_done, eng_pass, nominal_nonzero, meas_start;
    logic end_of_test_strobe, acquisition_done_strobe, pass_ind, fail_ind, tx_valid, tx_ready;
    logic [7:0] paddr, tx_data;
    logic [31:0] pwdata, prdata, rd, ctrl_v, lfsr, seed_v, rx_tail;
    logic [15:0] eng_value, rx_count, freq_corr;
    logic [15:0] vals [3];
    logic [3:0] eng_bin;
    logic [4:0] listen_addr;
    logic [14:0] handler_bin;
    logic [24:0] cfg_setup;
    logic [31:0] wv [6] = '{32'h1118231, 32'hc4231, 32'h80231, 32'h81231, 32'h200000, 32'h10400a};
    logic [31:0] ev [6] = '{32'h1118231, 32'h1118231, 32'h1118231, 32'h81231, 32'h104000, 32'h104000};
    int n_errors = 0;
    int cmp_count = 0;
    int n_starts = 0;
    int t0;

    hsro_top hsro_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .handler_start(handler_start), .eng_capt_done(eng_capt_done), .eng_calc_done(eng_calc_done),
        .eng_value(eng_value), .eng_bin(eng_bin), .eng_pass(eng_pass), .nominal_nonzero(nominal_nonzero),
        .listen_addr(listen_addr), .freq_corr(freq_corr), .meas_start(meas_start),
        .end_of_test_strobe(end_of_test_strobe), .acquisition_done_strobe(acquisition_done_strobe),
        .handler_bin(handler_bin), .pass_ind(pass_ind), .fail_ind(fail_ind), .cfg_setup(cfg_setup),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    hsro_partner hsro_partner_inst (.pclk(pclk), .presetn(presetn), .part_req(part_req), .stall(stall),
        .glue_on(glue_on), .test_end(end_of_test_strobe),
        .tx_valid(tx_valid), .tx_data(tx_data), .handler_start(handler_start), .tx_ready(tx_ready),
        .rx_count(rx_count), .rx_tail(rx_tail));

    // Clock, start counter and seeded listener stall pattern
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (meas_start === 1'b1) n_starts <= n_starts + 1;
        lfsr <= presetn ? {lfsr[0], lfsr[31:1]} : seed_v;
        stall <= lfsr[0] & lfsr[1];
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer, then one idle edge so requests never collide
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wait_start;
        int k;
        for (k = 0; k < 200 && meas_start !== 1'b1; k++) @(posedge pclk);
        if (k == 200) begin
            n_errors++;
            report_and_stop();
        end
    endtask
    function automatic int exp_len(input logic [3:0] c, input logic ps);
        logic [2:0] m;
        m = (c < 4'h8) ? c[2:0] : (ps ? ((c == OUT_PASS_BIN) ? 3'h1 : 3'h0) : 3'h7);
        return 17 * m[2] + 17 * m[1] + 10 * m[0];
    endfunction
    function automatic logic [14:0] exp_bin(input logic [3:0] b, input logic hs, input logic nz);
        logic [3:0] m;
        m = (!hs && b >= 4'h9 && b <= 4'hd) ? 4'he : b;
        return nz ? (15'h0001 << m) : 15'h0000;
    endfunction
    function automatic logic [15:0] med3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        if (a > b) return (b > c) ? b : ((a > c) ? c : a);
        return (a > c) ? a : ((b > c) ? c : b);
    endfunction
    // One measurement sequence of n passes with engine pulses, then output byte count
    task measure(input int n, input logic btn, input logic [3:0] bin, input logic ps, input logic [3:0] c);
        int i;
        int len;
        logic [15:0] base;
        base = rx_count;
        len = exp_len(c, ps);
        t0 = n_starts;
        eng_bin <= bin;
        eng_pass <= ps;
        if (btn) apb(1'b1, OFS_CTRL, ctrl_v | 32'h10);
        else part_req <= 1'b1;
        for (i = 0; i < n; i++) begin
            wait_start();
            chk(end_of_test_strobe, 1'b0);
            chk(acquisition_done_strobe, 1'b0);
            part_req <= 1'b0;
            eng_value <= vals[i];
            if (btn) apb(1'b1, OFS_CTRL, ctrl_v | 32'h10);
            repeat (2) @(posedge pclk);
            eng_capt_done <= 1'b1;
            @(posedge pclk);
            eng_capt_done <= 1'b0;
            @(posedge pclk);
            if (i == n - 1) chk({acquisition_done_strobe, end_of_test_strobe}, 2'b10);
            eng_calc_done <= 1'b1;
            @(posedge pclk);
            eng_calc_done <= 1'b0;
            @(posedge pclk);
        end
        chk(end_of_test_strobe, nominal_nonzero);
        chk(handler_bin, exp_bin(bin, ctrl_v[3], nominal_nonzero));
        chk({pass_ind, fail_ind}, nominal_nonzero ? {ps, !ps} : 2'b00);
        for (i = 0; i < 3000 && rx_count - base != 16'(len); i++) @(posedge pclk);
        repeat (40) @(posedge pclk);
        chk(n_starts - t0, n);
        chk(32'(rx_count - base), len);
        if (len % 17 == 10) chk(rx_tail, {8'h36, 8'h37, CHR_CR, CHR_LF});
        else if (len > 0) chk(rx_tail[15:0], {CHR_CR, CHR_LF});
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, part_req, glue_on} = '0;
        {eng_capt_done, eng_calc_done, eng_value, eng_bin, eng_pass} = '0;
        nominal_nonzero = 1'b1;
        listen_addr = 5'h15;
        freq_corr = 16'h7a3c;
        void'($urandom(62505));
        seed_v = $urandom;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_SETUP, 32'h0);
        chk(rd, {7'h0, SETUP_RST});
        apb(1'b1, OFS_INFO, 32'hffffffff);
        apb(1'b0, OFS_INFO, 32'h0);
        chk(rd, {freq_corr, 3'h0, listen_addr, FW_VERSION});
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, OFS_SETUP, 32'h1);
        apb(1'b0, OFS_SETUP, 32'h0);
        chk(rd, {7'h0, SETUP_RST});
        ctrl_v = 32'h7;
        apb(1'b1, OFS_CTRL, ctrl_v);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFS_SETUP, wv[i]);
            apb(1'b0, OFS_SETUP, 32'h0);
            chk(rd, ev[i]);
            chk(cfg_setup, ev[i]);
        end
        $display("settings test done");
        apb(1'b1, 8'hd8, 32'h36);
        apb(1'b1, 8'hdc, 32'h37);
        chk(err, 1'b0);
        for (int c = 0; c < 10; c++) begin
            ctrl_v = (c >= 5) ? 32'hf : 32'h7;
            apb(1'b1, OFS_CTRL, ctrl_v);
            apb(1'b1, OFS_SETUP, 32'h104000 | c);
            glue_on <= (c != 0);
            vals[0] = 16'($urandom);
            measure(1, c[0], (c < 5) ? 4'(c + 9) : 4'($urandom_range(14, 0)), 1'($urandom_range(1, 0)), 4'(c));
            $display("output code %0d test done", c);
        end
        nominal_nonzero <= 1'b0;
        measure(1, 1'b0, 4'h3, 1'b1, 4'h9);
        nominal_nonzero <= 1'b1;
        glue_on <= 1'b0;
        $display("zero nominal test done");
        ctrl_v = 32'h3;
        apb(1'b1, OFS_CTRL, ctrl_v);
        t0 = n_starts;
        part_req <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(n_starts - t0, 0);
        part_req <= 1'b0;
        ctrl_v = 32'h7;
        apb(1'b1, OFS_CTRL, ctrl_v);
        $display("untriggered test done");
        apb(1'b1, OFS_SETUP, 32'h1104000);
        for (int i = 0; i < 3; i++) vals[i] = 16'($urandom);
        measure(3, 1'b0, 4'h2, 1'b0, 4'h0);
        apb(1'b0, OFS_RESULT, 32'h0);
        chk(rd[15:0], med3(vals[0], vals[1], vals[2]));
        $display("median test done");
        report_and_stop();
    end
endmodule // test_hsro_top
